// ### rtl/ddr2_cmd_encoder.sv
/*
  Encodes one sequencer request into registered SDRAM command pins.
  Assumes the caller presents a pin pattern, bank, address and CKE each cycle.
*/
`timescale 1ns/10ps
`include "ddr2_seq_defines.svh"

module ddr2_cmd_encoder
  import ddr2_seq_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Requested command
  input  wire logic [3:0]   pins_i,
  input  wire logic [2:0]   bank_i,
  input  wire logic [13:0]  addr_i,
  input  wire logic         cke_i,
  // Pins to the SDRAMs
  output dram_cmd_type      cmd_o
);

  // Register the pins; a deselect ignores bank and address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_o <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 bank: 3'h0, addr: 14'h0000};
    end else begin
      cmd_o.cke   <= cke_i;
      cmd_o.cs_n  <= pins_i[3];
      cmd_o.ras_n <= pins_i[2];
      cmd_o.cas_n <= pins_i[1];
      cmd_o.we_n  <= pins_i[0];
      cmd_o.bank  <= pins_i[3] ? 3'h0 : bank_i;
      cmd_o.addr  <= pins_i[3] ? 14'h0000 : addr_i;
    end
  end

endmodule

// ### rtl/ddr2_init_command_sequencer.sv
/*
  DDR2 power-up sequencer and command scheduler. Initialization runs
  through module buffer registers with status polling; afterwards access,
  refresh and low-power commands go straight to the SDRAM pins.
  Assumes one 100 MHz clock, synchronous inputs, and cache banks that keep
  their own request limits.
*/
`timescale 1ns/10ps
`include "ddr2_seq_defines.svh"

module ddr2_init_command_sequencer
  import ddr2_seq_pkg::*;
#(
  parameter int STABLE_CYCLES = `STABLE_CYCLES,
  parameter int REFRESH_COUNT = `MIN_REFRESHES,
  parameter bit USE_OCD_CAL   = 1'b0
)(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  // Buffer register port
  output buf_cmd_type        buf_cmd_o,
  output logic               buf_cmd_vld_o,
  input  wire logic          buf_done_i,
  // Calibration engine
  output logic               ocd_start_o,
  input  wire logic          ocd_done_i,
  // Access requests from the cache bank
  input  wire logic          req_vld_i,
  input  access_req_type     req_i,
  output logic               req_ack_o,
  // Low power and refresh requests
  input  wire logic          refresh_req_i,
  input  wire logic          pwr_down_req_i,
  input  wire logic          self_ref_req_i,
  // SDRAM pins and status
  output dram_cmd_type       cmd_o,
  output logic               init_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and counters

  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [31:0]   wait_r;
  logic [7:0]    gap_r;
  logic [3:0]    ref_cnt_r;
  logic          buf_busy_r;
  logic          gap_run_r;
  logic          acc_act_r;
  logic          ocd_busy_r;
  access_req_type acc_r;
  logic [3:0]    pend_r;

  // Selected command for this cycle
  logic [3:0]  pins;
  logic [2:0]  bank;
  logic [13:0] addr;
  logic        cke;
  logic        buf_step;
  logic        direct_go;

  localparam int CKE_WAIT = `CKE_WAIT_CYCLES;

  // Buffer step completes when status reports delivery
  assign buf_step = buf_busy_r && buf_done_i;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STABLE:   if (wait_r == 32'(STABLE_CYCLES - 1)) state_nxt = ST_CKE_UP;
      ST_CKE_UP:   if (wait_r == 32'(CKE_WAIT - 1)) state_nxt = ST_PREA1;
      ST_PREA1:    if (buf_step) state_nxt = ST_EMRS2;
      ST_EMRS2:    if (buf_step) state_nxt = ST_EMRS3;
      ST_EMRS3:    if (buf_step) state_nxt = ST_EMRS1;
      ST_EMRS1:    if (buf_step) state_nxt = ST_MRS_RST;
      ST_MRS_RST:  if (buf_step) state_nxt = ST_PREA2;
      ST_PREA2:    if (buf_step) state_nxt = ST_REF;
      ST_REF:      if (buf_step && ref_cnt_r == 4'(REFRESH_COUNT - 1)) state_nxt = ST_MRS_OP;
      ST_MRS_OP:   if (buf_step) state_nxt = ST_OCD_GAP;
      ST_OCD_GAP: begin
        if (gap_r >= 8'(`OCD_GAP_CLOCKS) && !gap_run_r) begin
          if (USE_OCD_CAL) begin
            if (ocd_done_i && ocd_busy_r) state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_OCD_DFLT;
          end
        end
      end
      ST_OCD_DFLT: if (buf_step) state_nxt = ST_OCD_EXIT;
      ST_OCD_EXIT: if (buf_step) state_nxt = ST_IDLE;
      // A request still standing beside its own acknowledge is not taken again
      ST_IDLE: begin
        if (self_ref_req_i)      state_nxt = ST_SELF_REF;
        else if (pwr_down_req_i) state_nxt = ST_PWR_DOWN;
        else if (req_vld_i && !req_ack_o) state_nxt = ST_ACCESS;
      end
      ST_ACCESS:   if (acc_act_r) state_nxt = ST_IDLE;
      ST_PWR_DOWN: if (!pwr_down_req_i) state_nxt = ST_IDLE;
      ST_SELF_REF: if (!self_ref_req_i) state_nxt = ST_IDLE;
      default:     state_nxt = ST_STABLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) state_r <= ST_STABLE;
    else          state_r <= state_nxt;
  end

  // Interval counter for the stable clock and CKE wait
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)                 wait_r <= 32'h0;
    else if (state_nxt != state_r) wait_r <= 32'h0;
    else                          wait_r <= wait_r + 32'h1;
  end

  // Clocks since the EMRS3 write; saturates at the gap
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_r     <= 8'h00;
      gap_run_r <= 1'b0;
    end else if (state_r == ST_EMRS3 && buf_step) begin
      gap_r     <= 8'h00;
      gap_run_r <= 1'b1;
    end else if (gap_run_r) begin
      gap_r     <= gap_r + 8'h01;
      gap_run_r <= (gap_r < 8'(`OCD_GAP_CLOCKS - 1));
    end
  end

  // Refresh count during init
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)                         ref_cnt_r <= 4'h0;
    else if (state_r == ST_REF && buf_step) ref_cnt_r <= ref_cnt_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect buffer writes during init

  // Issue one buffer command per step, then poll its status
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_busy_r    <= 1'b0;
      buf_cmd_vld_o <= 1'b0;
      buf_cmd_o     <= '0;
    end else begin
      buf_cmd_vld_o <= 1'b0;
      if (buf_step) begin
        buf_busy_r <= 1'b0;
      end else if (!buf_busy_r && !init_done_o && state_r inside
                   {ST_PREA1, ST_EMRS2, ST_EMRS3, ST_EMRS1, ST_MRS_RST, ST_PREA2,
                    ST_REF, ST_MRS_OP, ST_OCD_DFLT, ST_OCD_EXIT}) begin
        buf_busy_r    <= 1'b1;
        buf_cmd_vld_o <= 1'b1;
        buf_cmd_o     <= '{bank: bank, addr: addr, pins: pins};
      end
    end
  end

  // Calibration handshake
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ocd_busy_r  <= 1'b0;
      ocd_start_o <= 1'b0;
    end else begin
      ocd_start_o <= 1'b0;
      if (USE_OCD_CAL && state_r == ST_OCD_GAP && !gap_run_r &&
          gap_r >= 8'(`OCD_GAP_CLOCKS) && !ocd_busy_r) begin
        ocd_busy_r  <= 1'b1;
        ocd_start_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command selection

  always_comb begin
    pins = `PINS_DESELECT;
    bank = 3'h0;
    addr = 14'h0000;
    cke  = 1'b1;
    unique case (state_r)
      ST_STABLE:   cke = 1'b0;
      ST_CKE_UP:   pins = `PINS_NOP;
      ST_PREA1, ST_PREA2: begin
        pins = `PINS_PRECHARGE;
        addr[`ADDR_AP_BIT] = 1'b1;
      end
      ST_EMRS2:    begin pins = `PINS_MRS; bank = `BANK_EMR2; addr = `OP_EMR_ZERO; end
      ST_EMRS3:    begin pins = `PINS_MRS; bank = `BANK_EMR3; addr = `OP_EMR_ZERO; end
      ST_EMRS1:    begin pins = `PINS_MRS; bank = `BANK_EMR1; addr = `OP_EMR1_DLL_ON; end
      ST_MRS_RST:  begin pins = `PINS_MRS; bank = `BANK_MR; addr = `OP_MRS_DLL_RST; end
      ST_REF:      pins = `PINS_REFRESH;
      ST_MRS_OP:   begin pins = `PINS_MRS; bank = `BANK_MR; addr = `OP_MRS_NORMAL; end
      ST_OCD_DFLT: begin pins = `PINS_MRS; bank = `BANK_EMR1; addr = `OP_EMR1_OCD_DFLT; end
      ST_OCD_EXIT: begin pins = `PINS_MRS; bank = `BANK_EMR1; addr = `OP_EMR1_OCD_EXIT; end
      ST_OCD_GAP:  pins = `PINS_NOP;
      ST_IDLE: begin
        pins = `PINS_NOP;
        if (self_ref_req_i) begin
          pins = `PINS_REFRESH;
          cke  = 1'b0;
        end else if (pwr_down_req_i) begin
          cke  = 1'b0;
        end else if (refresh_req_i) begin
          pins = `PINS_REFRESH;
        end
      end
      ST_ACCESS: begin
        bank = acc_r.bank;
        if (!acc_act_r) begin
          pins = `PINS_ACTIVATE;
          addr = acc_r.row;
        end else begin
          pins = acc_r.wr ? `PINS_WRITE : `PINS_READ;
          addr = {4'h0, acc_r.col};
          addr[`ADDR_AP_BIT] = 1'b1;
        end
      end
      ST_PWR_DOWN: begin
        pins = `PINS_NOP;
        cke  = !pwr_down_req_i;
      end
      ST_SELF_REF: begin
        pins = `PINS_DESELECT;
        cke  = !self_ref_req_i;
      end
      default: begin
        pins = `PINS_DESELECT;
        cke  = 1'b0;
      end
    endcase
  end

  // Direct pins after init and in ST_STABLE and ST_CKE_UP; during buffered init the pins idle with NOP
  assign direct_go = init_done_o || state_r == ST_STABLE || state_r == ST_CKE_UP;

  ddr2_cmd_encoder u_enc (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pins_i  (direct_go ? pins : `PINS_NOP),
    .bank_i  (bank),
    .addr_i  (addr),
    .cke_i   (cke),
    .cmd_o   (cmd_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access tracking and acknowledge

  // Capture the request; activate then column command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_r     <= '0;
      acc_act_r <= 1'b0;
      req_ack_o <= 1'b0;
    end else begin
      req_ack_o <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_ACCESS) begin
        acc_r     <= req_i;
        acc_act_r <= 1'b0;
      end else if (state_r == ST_ACCESS) begin
        acc_act_r <= ~acc_act_r;
        req_ack_o <= acc_act_r;
      end
    end
  end

  // Requests taken and not yet acknowledged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_r <= 4'h0;
    end else if (state_r == ST_IDLE && state_nxt == ST_ACCESS) begin
      pend_r <= pend_r + 4'h1;
    end else if (req_ack_o) begin
      pend_r <= pend_r - 4'h1;
    end
  end

  // Init finished flag
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)               init_done_o <= 1'b0;
    else if (state_nxt == ST_IDLE) init_done_o <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence mode_write_s;
    !cmd_o.cs_n && !cmd_o.ras_n && !cmd_o.cas_n && !cmd_o.we_n;
  endsequence

  mode_write_pins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    mode_write_s |-> cmd_o.cke && $past(cmd_o.cke))
    else $error("mode write without CKE high");

  stable_no_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_r == ST_STABLE |-> !buf_cmd_vld_o && !cmd_o.cke)
    else $error("command during clock stabilization");

  cke_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_r == ST_PREA1) |-> $past(state_r == ST_CKE_UP, CKE_WAIT))
    else $error("precharge before CKE wait");

  init_order_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_r == ST_EMRS1) |-> $past(state_r == ST_EMRS3))
    else $error("EMRS1 not after EMRS3");

  buf_only_init_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    buf_cmd_vld_o |-> !init_done_o ##1 buf_busy_r)
    else $error("buffer write after init");

  read_ap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!cmd_o.cs_n && cmd_o.ras_n && !cmd_o.cas_n) |-> cmd_o.addr[`ADDR_AP_BIT])
    else $error("access without auto-precharge");

  ack_after_col_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    req_ack_o |-> (cmd_o.ras_n && !cmd_o.cas_n) and $past(state_r == ST_ACCESS))
    else $error("acknowledge without column command");

  refresh_min_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_r == ST_MRS_OP) |-> ref_cnt_r >= 4'(REFRESH_COUNT))
    else $error("too few refreshes");

  buf_mode_pins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    buf_cmd_vld_o && state_r inside {ST_EMRS2, ST_EMRS3, ST_EMRS1, ST_MRS_RST, ST_MRS_OP,
                                     ST_OCD_DFLT, ST_OCD_EXIT} |-> buf_cmd_o.pins == `PINS_MRS)
    else $error("mode write with wrong pins");

  pend_limit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pend_r <= 4'(`MAX_OUTSTANDING))
    else $error("too many requests outstanding");

endmodule

// ### rtl/ddr2_seq_defines.svh
/*
  Timing counts, command pin patterns and mode-register op-codes for the
  DDR2 init and command sequencer. Assumes a 100 MHz controller clock.
*/
`ifndef DDR2_SEQ_DEFINES_SVH
`define DDR2_SEQ_DEFINES_SVH

// Clock period and documented times
`define CLK_PERIOD_NS      10
`define STABLE_TIME_US     200
`define CKE_WAIT_NS        400
`define OCD_GAP_CLOCKS     200
// Derived counts (least times, rounded up)
`define STABLE_CYCLES      ((`STABLE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CKE_WAIT_CYCLES    ((`CKE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_REFRESHES      2
// Command pins {cs_n, ras_n, cas_n, we_n}
`define PINS_MRS           4'h0
`define PINS_REFRESH       4'h1
`define PINS_PRECHARGE     4'h2
`define PINS_ACTIVATE      4'h3
`define PINS_WRITE         4'h4
`define PINS_READ          4'h5
`define PINS_NOP           4'h7
`define PINS_DESELECT      4'hF
// Address bit positions
`define ADDR_AP_BIT        10
`define ADDR_DLL_RST_BIT   8
// Bank codes of the mode registers
`define BANK_MR            3'h0
`define BANK_EMR1          3'h1
`define BANK_EMR2          3'h2
`define BANK_EMR3          3'h3
// Mode register op-codes
`define OP_MRS_DLL_RST     14'h0100
`define OP_MRS_NORMAL      14'h0000
`define OP_EMR_ZERO        14'h0000
`define OP_EMR1_DLL_ON     14'h0000
`define OP_EMR1_OCD_DFLT   14'h0380
`define OP_EMR1_OCD_EXIT   14'h0000
// Outstanding requests allowed per cache bank
`define MAX_OUTSTANDING    8

`endif

// ### rtl/ddr2_seq_pkg.sv
/*
  Types for the DDR2 init and command sequencer.
  Assumes the defines header is compiled alongside.
*/
package ddr2_seq_pkg;

  // One command on the SDRAM pins
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  bank;
    logic [13:0] addr;
  } dram_cmd_type;

  // Access request from a cache bank
  typedef struct packed {
    logic        wr;
    logic [2:0]  bank;
    logic [13:0] row;
    logic [9:0]  col;
  } access_req_type;

  // Indirect buffer-register command
  typedef struct packed {
    logic [2:0]  bank;
    logic [13:0] addr;
    logic [3:0]  pins;
  } buf_cmd_type;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_STABLE   = 5'h00,
    ST_CKE_UP   = 5'h01,
    ST_PREA1    = 5'h02,
    ST_EMRS2    = 5'h03,
    ST_EMRS3    = 5'h04,
    ST_EMRS1    = 5'h05,
    ST_MRS_RST  = 5'h06,
    ST_PREA2    = 5'h07,
    ST_REF      = 5'h08,
    ST_MRS_OP   = 5'h09,
    ST_OCD_GAP  = 5'h0A,
    ST_OCD_DFLT = 5'h0B,
    ST_OCD_EXIT = 5'h0C,
    ST_IDLE     = 5'h0D,
    ST_ACCESS   = 5'h0E,
    ST_PWR_DOWN = 5'h0F,
    ST_SELF_REF = 5'h10
  } seq_state_type;

endpackage

// ### testbench/ddr2_buf_model.sv
/*
  Behavioural module buffer: logs each buffer command with its cycle stamp
  and reports delivery after a short or a long delay, alternately.
  Assumes the sequencer issues one buffer command at a time.
*/
`timescale 1ns/10ps

module ddr2_buf_model
  import ddr2_seq_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  // Buffer register port
  input  buf_cmd_type buf_cmd_i,
  input  wire logic   buf_cmd_vld_i,
  output logic        buf_done_o
);
  buf_cmd_type logq[$];
  int          stamp[$];
  int          cyc;
  int          wait_cnt;
  int          overlap;
  logic        busy;

  //////////////////////////////////////////////////////////////////////////////
  // Log commands, answer polling after a prompt or slow delay
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy = 1'b0;
      cyc = 0;
      overlap = 0;
      buf_done_o <= 1'b0;
    end else begin
      cyc++;
      buf_done_o <= 1'b0;
      if (buf_cmd_vld_i === 1'b1) begin
        if (busy) overlap++;
        logq.push_back(buf_cmd_i);
        stamp.push_back(cyc);
        busy = 1'b1;
        wait_cnt = (logq.size() % 2 == 1) ? 1 : 7;
      end else if (busy) begin
        if (wait_cnt == 0) begin
          buf_done_o <= 1'b1;
          busy = 1'b0;
        end else begin
          wait_cnt--;
        end
      end
    end
  end
endmodule

// ### testbench/ddr2_init_command_sequencer_bench.sv
/*
  Self-checking bench for the DDR2 init and command sequencer.
  Assumes the design defines header and package are compiled first.
*/
`timescale 1ns/10ps
`include "ddr2_seq_defines.svh"

`define CHECK_EQ(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module ddr2_init_command_sequencer_bench
  import ddr2_seq_pkg::*;
;
  localparam int STABLE = 50;
  localparam buf_cmd_type exp_c [11] = '{
    '{3'h0, 14'h0400, `PINS_PRECHARGE}, '{`BANK_EMR2, `OP_EMR_ZERO, `PINS_MRS},
    '{`BANK_EMR3, `OP_EMR_ZERO, `PINS_MRS}, '{`BANK_EMR1, `OP_EMR1_DLL_ON, `PINS_MRS},
    '{`BANK_MR, `OP_MRS_DLL_RST, `PINS_MRS}, '{3'h0, 14'h0400, `PINS_PRECHARGE},
    '{3'h0, 14'h0000, `PINS_REFRESH}, '{3'h0, 14'h0000, `PINS_REFRESH},
    '{`BANK_MR, `OP_MRS_NORMAL, `PINS_MRS}, '{`BANK_EMR1, `OP_EMR1_OCD_DFLT, `PINS_MRS},
    '{`BANK_EMR1, `OP_EMR1_OCD_EXIT, `PINS_MRS}};
  localparam int kind_c [11] = '{1, 2, 2, 2, 2, 1, 0, 0, 2, 2, 2};

  logic           clk_i;
  logic           rst_b_i;
  buf_cmd_type    buf_cmd;
  logic           buf_cmd_vld;
  logic           buf_done;
  logic           req_vld_i;
  access_req_type req_i;
  logic           req_ack_o;
  logic           refresh_req_i;
  logic           pwr_down_req_i;
  logic           self_ref_req_i;
  dram_cmd_type   cmd_o;
  logic           init_done_o;
  int             error_cnt;
  int             total_checks;
  buf_cmd_type    buf_cmd_c;
  logic           buf_vld_c;
  logic           buf_done_c;
  logic           ocd_start_c;
  logic           ocd_done_c;
  logic           init_done_c;
  int             ocd_cnt;
  int             ocd_cyc;
  int             cyc_c;

  ddr2_init_command_sequencer #(
    .STABLE_CYCLES (STABLE),
    .REFRESH_COUNT (2),
    .USE_OCD_CAL   (1'b0)
  ) i_dut (
    .clk_i          (clk_i),
    .rst_b_i        (rst_b_i),
    .buf_cmd_o      (buf_cmd),
    .buf_cmd_vld_o  (buf_cmd_vld),
    .buf_done_i     (buf_done),
    .ocd_start_o    (),
    .ocd_done_i     (1'b0),
    .req_vld_i      (req_vld_i),
    .req_i          (req_i),
    .req_ack_o      (req_ack_o),
    .refresh_req_i  (refresh_req_i),
    .pwr_down_req_i (pwr_down_req_i),
    .self_ref_req_i (self_ref_req_i),
    .cmd_o          (cmd_o),
    .init_done_o    (init_done_o)
  );

  ddr2_buf_model i_buf (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .buf_cmd_i     (buf_cmd),
    .buf_cmd_vld_i (buf_cmd_vld),
    .buf_done_o    (buf_done)
  );

  // Second instance: calibration handshake instead of default writes
  ddr2_init_command_sequencer #(
    .STABLE_CYCLES (STABLE),
    .REFRESH_COUNT (2),
    .USE_OCD_CAL   (1'b1)
  ) i_dut_cal (
    .clk_i          (clk_i),
    .rst_b_i        (rst_b_i),
    .buf_cmd_o      (buf_cmd_c),
    .buf_cmd_vld_o  (buf_vld_c),
    .buf_done_i     (buf_done_c),
    .ocd_start_o    (ocd_start_c),
    .ocd_done_i     (ocd_done_c),
    .req_vld_i      (req_vld_i),
    .req_i          (req_i),
    .req_ack_o      (),
    .refresh_req_i  (refresh_req_i),
    .pwr_down_req_i (pwr_down_req_i),
    .self_ref_req_i (self_ref_req_i),
    .cmd_o          (),
    .init_done_o    (init_done_c)
  );

  ddr2_buf_model i_buf_cal (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .buf_cmd_i     (buf_cmd_c),
    .buf_cmd_vld_i (buf_vld_c),
    .buf_done_o    (buf_done_c)
  );

  // Calibration engine: counts starts, stamps the cycle, reports done
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ocd_done_c <= 1'b0;
      ocd_cnt    <= 0;
      ocd_cyc    <= 0;
      cyc_c      <= 0;
    end else begin
      cyc_c <= cyc_c + 1;
      if (ocd_start_c === 1'b1) begin
        ocd_done_c <= 1'b1;
        ocd_cnt    <= ocd_cnt + 1;
        ocd_cyc    <= cyc_c + 1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock and helpers
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic quiet(input dram_cmd_type c);
    return (c.cs_n === 1'b1) || ({c.ras_n, c.cas_n, c.we_n} === 3'b111);
  endfunction

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Power-up wait, CKE timing and buffered init order
  task automatic t_init();
    int n;
    n = 0;
    while (cmd_o.cke !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    `CHECK_EQ("stable wait", 1'b1, n >= STABLE)
    `CHECK_EQ("early buffer cmds", 0, i_buf.logq.size())
    `CHECK_EQ("cke rise cmd", 1'b1, quiet(cmd_o))
    n = 0;
    while (buf_cmd_vld !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    `CHECK_EQ("cke to precharge", 1'b1, n >= `CKE_WAIT_CYCLES)
    n = 0;
    while (init_done_o !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    `CHECK_EQ("buffer cmd count", 11, i_buf.logq.size())
    `CHECK_EQ("poll overlap", 0, i_buf.overlap)
    if (i_buf.logq.size() == 11) begin
      for (int i = 0; i < 11; i++) begin
        `CHECK_EQ("buf pins", exp_c[i].pins, i_buf.logq[i].pins)
        if (kind_c[i] == 1) `CHECK_EQ("buf a10", 1'b1, i_buf.logq[i].addr[10])
        if (kind_c[i] == 2) `CHECK_EQ("buf mode cmd", exp_c[i], i_buf.logq[i])
      end
      `CHECK_EQ("ocd gap", 1'b1, i_buf.stamp[9] - i_buf.stamp[2] >= `OCD_GAP_CLOCKS)
    end
    `CHECK_EQ("cal init done", 1'b1, init_done_c)
    `CHECK_EQ("cal buffer cmds", 9, i_buf_cal.logq.size())
    `CHECK_EQ("cal starts", 1, ocd_cnt)
    if (i_buf_cal.logq.size() >= 3) begin
      `CHECK_EQ("cal gap", 1'b1, ocd_cyc - i_buf_cal.stamp[2] >= `OCD_GAP_CLOCKS)
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // One access: activate, then auto-precharge read or write with ack
  task automatic t_access(input logic wr, input logic [2:0] bk, input logic [13:0] row,
                          input logic [9:0] col);
    int n;
    @(posedge clk_i);
    req_i <= '{wr, bk, row, col};
    req_vld_i <= 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while ({cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} !== `PINS_ACTIVATE && n < 20);
    `CHECK_EQ("activate addr", {bk, row}, {cmd_o.bank, cmd_o.addr})
    tick();
    `CHECK_EQ("access pins", wr ? `PINS_WRITE : `PINS_READ,
              {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n})
    `CHECK_EQ("access col", {bk, 1'b1, col}, {cmd_o.bank, cmd_o.addr[10:0]})
    `CHECK_EQ("ack", 1'b1, req_ack_o)
    @(posedge clk_i);
    req_vld_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Auto-refresh with CKE high in both cycles
  task automatic t_refresh();
    int   n;
    logic prev;
    @(posedge clk_i);
    refresh_req_i <= 1'b1;
    #1;
    n = 0;
    prev = 1'b0;
    do begin
      prev = cmd_o.cke;
      tick();
      n++;
    end while ({cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} !== `PINS_REFRESH && n < 20);
    `CHECK_EQ("refresh cke", 2'b11, {prev, cmd_o.cke})
    @(posedge clk_i);
    refresh_req_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Power-down or self-refresh entry and exit by CKE edges
  task automatic t_low(input logic self);
    int n;
    @(posedge clk_i);
    if (self) self_ref_req_i <= 1'b1;
    else pwr_down_req_i <= 1'b1;
    n = 0;
    while (cmd_o.cke !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    if (self) `CHECK_EQ("sref entry", `PINS_REFRESH,
                        {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n})
    else `CHECK_EQ("pdown entry", 1'b1, quiet(cmd_o))
    repeat (5) tick();
    `CHECK_EQ("low power cke", 1'b0, cmd_o.cke)
    @(posedge clk_i);
    self_ref_req_i <= 1'b0;
    pwr_down_req_i <= 1'b0;
    n = 0;
    while (cmd_o.cke !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    `CHECK_EQ("exit cke", 1'b1, cmd_o.cke)
    `CHECK_EQ("exit cmd", 1'b1, quiet(cmd_o))
    repeat (4) @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    error_cnt = 0;
    total_checks = 0;
    rst_b_i = 1'b0;
    req_vld_i = 1'b0;
    req_i = '0;
    refresh_req_i = 1'b0;
    pwr_down_req_i = 1'b0;
    self_ref_req_i = 1'b0;
    repeat (5) tick();
    `CHECK_EQ("reset pins", 2'b01, {cmd_o.cke, cmd_o.cs_n})
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_init();
    t_access(1'b0, 3'h0, 14'h3FFF, 10'h3FF);
    t_access(1'b1, 3'h7, 14'h0000, 10'h000);
    for (int i = 0; i < 8; i++) begin
      t_access(i[0], i[2:0], 14'h1234 + 14'(i), 10'h155);
    end
    t_refresh();
    t_low(1'b0);
    t_low(1'b1);
    t_access(1'b1, 3'h5, 14'h2AAA, 10'h2AA);
    `CHECK_EQ("direct after init", 11, i_buf.logq.size())
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
endmodule
